// >>> rtl/kmc_top.sv
`timescale 1ns/1ps
module kmc_top #(
  parameter int MSG_CYC_P   = kmc_pkg::MSG_CYC,
  parameter int DEB_CYC_P   = kmc_pkg::DEB_CYC,
  parameter int BLINK_CYC_P = kmc_pkg::BLINK_CYC
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RST,
  // Front-panel keys, raw levels
  input  wire kmc_pkg::kmc_keys_t KEYS,
  // Drive state
  input  wire logic               FAULT,
  input  wire logic [4:0]         FAULT_CODE,
  input  wire logic               DIAG,
  // Monitor source
  output logic [4:0]              MON_SEL,
  input  wire logic [19:0]        MON_VALUE,
  input  wire logic               MON_NEG,
  // Parameter store
  output logic [3:0]              PAR_GROUP,
  output logic [7:0]              PAR_INDEX,
  input  wire logic [19:0]        PAR_VALUE,
  input  wire logic               PAR_NEG,
  input  wire logic               PAR_WIDE,
  output logic                    PAR_WR,
  output logic [19:0]             PAR_WDATA,
  output logic                    PAR_WNEG,
  input  wire kmc_pkg::kmc_res_t  SET_RESULT,
  output logic                    DIAG_EXEC,
  // Display
  output kmc_pkg::kmc_disp_t      DISP
);

  localparam logic [kmc_pkg::TMR_W-1:0] MSG_END_CNT =
    kmc_pkg::TMR_W'(MSG_CYC_P - 1);
  localparam logic [kmc_pkg::TMR_W-1:0] BLINK_END =
    kmc_pkg::TMR_W'(BLINK_CYC_P - 1);

  kmc_pkg::kmc_keys_t                prs;
  kmc_pkg::kmc_state_t               st_r, st_nxt;
  logic [kmc_pkg::TMR_W-1:0]         tmr_r, tmr_nxt;
  logic [4:0]                        mon_r, mon_nxt;
  logic [3:0]                        grp_r, grp_nxt;
  logic [7:0]                        idx_r, idx_nxt;
  logic [19:0]                       edit_r, edit_nxt;
  logic                              eneg_r, eneg_nxt;
  logic                              wide_r, wide_nxt;
  logic [2:0]                        cur_r, cur_nxt;
  kmc_pkg::kmc_res_t                 res_r, res_nxt;
  logic                              wr_r, wr_nxt;
  logic                              dex_r, dex_nxt;
  logic [kmc_pkg::TMR_W-1:0]         blk_cnt_r, blk_cnt_nxt;
  logic                              blk_r, blk_nxt;
  logic [kmc_pkg::NDIG-1:0][4:0]     gl, mon_gl, edit_gl;
  logic [kmc_pkg::NDIG-1:0]          dp;
  kmc_pkg::kmc_disp_t                disp_r, disp_nxt;
  logic [4:0]                        flt, sym_hi, sym_lo, flt_hi, flt_lo;
  logic [2:0]                        cur_max;
  logic                              upd;

  kmc_debounce #(
    .DEB_CYC_P (DEB_CYC_P)
  ) u_deb (
    .CLK   (CLK),
    .RST   (RST),
    .RAW   (KEYS),
    .PRESS (prs)
  );

  function automatic logic [3:0] dstep(input logic [3:0] d,
                                       input logic up);
    if (up)
      return (d == kmc_pkg::BCD_MAX) ? 4'h0 : d + 4'h1;
    else
      return (d == 4'h0) ? kmc_pkg::BCD_MAX : d - 4'h1;
  endfunction : dstep

  //==========================================================
  // Menu sequencer
  assign upd     = prs.up | prs.down;
  assign cur_max = wide_r ? kmc_pkg::CUR_WIDE : kmc_pkg::CUR_NARR;

  always_comb
  begin
    st_nxt   = st_r;
    tmr_nxt  = (tmr_r == '0) ? tmr_r : tmr_r - 1'b1;
    mon_nxt  = mon_r;
    grp_nxt  = grp_r;
    idx_nxt  = idx_r;
    edit_nxt = edit_r;
    eneg_nxt = eneg_r;
    wide_nxt = wide_r;
    cur_nxt  = cur_r;
    res_nxt  = res_r;
    wr_nxt   = 1'b0;
    dex_nxt  = 1'b0;
    unique case (st_r)
      kmc_pkg::S_SPLASH:
        if (tmr_r == '0)
          st_nxt = kmc_pkg::S_MON;
      kmc_pkg::S_MON, kmc_pkg::S_MON_SYM:
        if (prs.mode)
          st_nxt = kmc_pkg::S_PAR;
        else if (upd)
        begin
          if (prs.up)
            mon_nxt = (mon_r == kmc_pkg::MON_LAST) ? 5'h00 : mon_r + 5'h01;
          else
            mon_nxt = (mon_r == 5'h00) ? kmc_pkg::MON_LAST : mon_r - 5'h01;
          st_nxt  = kmc_pkg::S_MON_SYM;
          tmr_nxt = MSG_END_CNT;
        end
        else if (st_r == kmc_pkg::S_MON_SYM && tmr_r == '0)
          st_nxt = kmc_pkg::S_MON;
      kmc_pkg::S_PAR:
        if (prs.mode)
          st_nxt = kmc_pkg::S_MON;
        else if (prs.set)
        begin
          st_nxt   = kmc_pkg::S_SET;
          edit_nxt = PAR_VALUE;
          eneg_nxt = PAR_NEG;
          wide_nxt = PAR_WIDE;
          cur_nxt  = 3'h0;
        end
        else if (prs.shift)
          grp_nxt = (grp_r == kmc_pkg::GRP_LAST) ? 4'h0 : grp_r + 4'h1;
        else if (upd)
        begin
          idx_nxt[3:0] = dstep(idx_r[3:0], prs.up);
          if ((prs.up && idx_r[3:0] == kmc_pkg::BCD_MAX) ||
              (!prs.up && idx_r[3:0] == 4'h0))
            idx_nxt[7:4] = dstep(idx_r[7:4], prs.up);
        end
      kmc_pkg::S_SET:
        if (prs.mode)
          st_nxt = kmc_pkg::S_PAR;
        else if (prs.set)
        begin
          tmr_nxt = MSG_END_CNT;
          if (DIAG)
          begin
            dex_nxt = 1'b1;
            st_nxt  = kmc_pkg::S_END;
          end
          else
          begin
            wr_nxt = 1'b1;
            st_nxt = kmc_pkg::S_STAT;
          end
        end
        else if (prs.shift)
        begin
          if (cur_r >= cur_max)
          begin
            cur_nxt  = 3'h0;
            eneg_nxt = !eneg_r;
          end
          else
            cur_nxt = cur_r + 3'h1;
        end
        else if (upd)
          edit_nxt[{cur_r, 2'b00} +: 4] =
            dstep(edit_r[{cur_r, 2'b00} +: 4], prs.up);
      kmc_pkg::S_STAT:
      begin
        if (wr_r)
          res_nxt = SET_RESULT;
        if (tmr_r == '0)
        begin
          if (res_r == kmc_pkg::RES_OK)
          begin
            st_nxt  = kmc_pkg::S_END;
            tmr_nxt = MSG_END_CNT;
          end
          else
            st_nxt = kmc_pkg::S_PAR;
        end
      end
      kmc_pkg::S_END:
        if (tmr_r == '0)
          st_nxt = kmc_pkg::S_PAR;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_r   <= kmc_pkg::S_SPLASH;
      tmr_r  <= MSG_END_CNT;
      mon_r  <= kmc_pkg::MON_INIT;
      grp_r  <= 4'h0;
      idx_r  <= 8'h00;
      edit_r <= 20'h00000;
      eneg_r <= 1'b0;
      wide_r <= 1'b0;
      cur_r  <= 3'h0;
      res_r  <= kmc_pkg::RES_OK;
      wr_r   <= 1'b0;
      dex_r  <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      tmr_r  <= tmr_nxt;
      mon_r  <= mon_nxt;
      grp_r  <= grp_nxt;
      idx_r  <= idx_nxt;
      edit_r <= edit_nxt;
      eneg_r <= eneg_nxt;
      wide_r <= wide_nxt;
      cur_r  <= cur_nxt;
      res_r  <= res_nxt;
      wr_r   <= wr_nxt;
      dex_r  <= dex_nxt;
    end
  end

  //==========================================================
  // Blink phase for the digit under the cursor
  always_comb
  begin
    blk_cnt_nxt = blk_cnt_r + 1'b1;
    blk_nxt     = blk_r;
    if (blk_cnt_r == BLINK_END)
    begin
      blk_cnt_nxt = '0;
      blk_nxt     = !blk_r;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      blk_cnt_r <= '0;
      blk_r     <= 1'b0;
    end
    else
    begin
      blk_cnt_r <= blk_cnt_nxt;
      blk_r     <= blk_nxt;
    end
  end

  //==========================================================
  // Display composition
  // Out-of-range fault codes saturate rather than showing garbage
  assign flt = (FAULT_CODE < kmc_pkg::FLT_MIN) ? kmc_pkg::FLT_MIN :
               (FAULT_CODE > kmc_pkg::FLT_MAX) ? kmc_pkg::FLT_MAX :
               FAULT_CODE;
  assign flt_hi = (flt >= kmc_pkg::DEC_20)  ? kmc_pkg::G_2 :
                  (flt >= kmc_pkg::DEC_TEN) ? kmc_pkg::G_1 : kmc_pkg::G_0;
  assign flt_lo = (flt >= kmc_pkg::DEC_20)  ? flt - kmc_pkg::DEC_20 :
                  (flt >= kmc_pkg::DEC_TEN) ? flt - kmc_pkg::DEC_TEN : flt;
  assign sym_hi = (mon_r >= kmc_pkg::DEC_TEN) ? kmc_pkg::G_1 : kmc_pkg::G_0;
  assign sym_lo = (mon_r >= kmc_pkg::DEC_TEN) ? mon_r - kmc_pkg::DEC_TEN
                                              : mon_r;

  genvar d;
  generate
    for (d = 0; d < kmc_pkg::NDIG; d++)
    begin : g_dig
      assign mon_gl[d]  = {1'b0, MON_VALUE[4*d +: 4]};
      assign edit_gl[d] = (cur_r == 3'(d) && blk_r) ? kmc_pkg::G_BLK :
                          {1'b0, edit_r[4*d +: 4]};
      assign disp_nxt.seg[d] = kmc_pkg::seg_of(gl[d]);
    end
  endgenerate
  assign disp_nxt.dp = dp;

  always_comb
  begin
    gl = {kmc_pkg::NDIG{kmc_pkg::G_BLK}};
    dp = '0;
    unique case (st_r)
      kmc_pkg::S_SPLASH, kmc_pkg::S_MON_SYM:
        gl = {kmc_pkg::G_C, kmc_pkg::G_O, kmc_pkg::G_DASH,
              sym_hi, sym_lo};
      kmc_pkg::S_MON:
      begin
        gl = mon_gl;
        if (MON_NEG && MON_VALUE[19:16] != 4'h0)
          dp = '1;
        else if (MON_NEG)
          gl[4] = kmc_pkg::G_DASH;
      end
      kmc_pkg::S_PAR:
        gl = {kmc_pkg::G_P, 1'b0, grp_r, kmc_pkg::G_BLK,
              1'b0, idx_r[7:4], 1'b0, idx_r[3:0]};
      kmc_pkg::S_SET:
      begin
        gl = edit_gl;
        if (eneg_r && wide_r)
          dp = '1;
        else if (eneg_r)
          gl[4] = kmc_pkg::G_DASH;
      end
      kmc_pkg::S_STAT:
        // Verdict is not registered yet in the write cycle
        gl = kmc_pkg::MSG_RES[wr_r ? SET_RESULT : res_r];
      kmc_pkg::S_END:
        gl = kmc_pkg::MSG_END;
    endcase
    if (FAULT)
    begin
      gl = {kmc_pkg::G_A, kmc_pkg::G_L, kmc_pkg::G_E,
            flt_hi, flt_lo};
      dp = '0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      disp_r <= '0;
    else
      disp_r <= disp_nxt;
  end

  assign DISP      = disp_r;
  assign MON_SEL   = mon_r;
  assign PAR_GROUP = grp_r;
  assign PAR_INDEX = idx_r;
  assign PAR_WR    = wr_r;
  assign PAR_WDATA = edit_r;
  assign PAR_WNEG  = eneg_r;
  assign DIAG_EXEC = dex_r;

  //==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  splash_exit_a: assert property (
    st_r == kmc_pkg::S_SPLASH && tmr_r == '0 |=> st_r == kmc_pkg::S_MON)
    else $error("splash did not hand over to monitor");
  mon_step_a: assert property (
    st_r == kmc_pkg::S_MON && !prs.mode && upd |=>
      st_r == kmc_pkg::S_MON_SYM && mon_r != $past(mon_r) &&
      tmr_r == MSG_END_CNT)
    else $error("monitor step did not show symbol");
  group_shift_a: assert property (
    st_r == kmc_pkg::S_PAR && prs.shift && !prs.mode && !prs.set |=>
      grp_r != $past(grp_r))
    else $error("shift did not change group");
  set_enter_a: assert property (
    st_r == kmc_pkg::S_PAR && prs.set && !prs.mode |=>
      st_r == kmc_pkg::S_SET && edit_r == $past(PAR_VALUE))
    else $error("setting mode missed current value");
  cursor_move_a: assert property (
    st_r == kmc_pkg::S_SET && prs.shift && !prs.mode && !prs.set &&
      cur_r < cur_max |=> cur_r == $past(cur_r) + 3'h1)
    else $error("cursor did not move left");
  write_cause_a: assert property (
    wr_r |-> $past(st_r) == kmc_pkg::S_SET && $past(prs.set) &&
      st_r == kmc_pkg::S_STAT)
    else $error("parameter written without set");
  end_return_a: assert property (
    st_r == kmc_pkg::S_END && tmr_r == '0 |=> st_r == kmc_pkg::S_PAR)
    else $error("end message did not return");
  status_hold_a: assert property (
    wr_r |-> tmr_r == MSG_END_CNT ##1 st_r == kmc_pkg::S_STAT)
    else $error("status message not held");
  abort_edit_a: assert property (
    st_r == kmc_pkg::S_SET && prs.mode |=>
      st_r == kmc_pkg::S_PAR && !wr_r)
    else $error("abort from setting misbehaved");
  alarm_show_a: assert property (
    FAULT |=> DISP.seg[4] == kmc_pkg::seg_of(kmc_pkg::G_A) &&
      DISP.seg[3] == kmc_pkg::seg_of(kmc_pkg::G_L))
    else $error("alarm prefix missing");
  diag_exec_a: assert property (
    st_r == kmc_pkg::S_SET && prs.set && !prs.mode && DIAG |=>
      DIAG_EXEC && !PAR_WR)
    else $error("diagnosis set did not execute");
  neg_wide_a: assert property (
    st_r == kmc_pkg::S_SET && eneg_r && wide_r && !FAULT |=>
      DISP.dp == '1)
    else $error("negative wide value lacks points");
  neg_narrow_a: assert property (
    st_r == kmc_pkg::S_SET && eneg_r && !wide_r && !FAULT |=>
      DISP.seg[4] == kmc_pkg::seg_of(kmc_pkg::G_DASH))
    else $error("negative narrow value lacks minus");

  save_seen_c: cover property (wr_r ##1 st_r == kmc_pkg::S_STAT);
  end_seen_c: cover property (st_r == kmc_pkg::S_END);
  neg_toggle_c: cover property (st_r == kmc_pkg::S_SET && $rose(eneg_r));
  abort_par_c: cover property (st_r == kmc_pkg::S_PAR && prs.mode);

endmodule : kmc_top

// >>> rtl/kmc_pkg.sv
//==========================================================
// Behaviour
// - At power-up show monitor code about one second, then enter monitor.
// - In monitor, up/down steps quantity and shows its symbol one second.
// - Mode enters parameter mode; shift picks group, up/down picks code.
// - Set in parameter mode enters setting mode showing current value.
// - In setting, shift moves cursor left, digit blinks, up/down edit.
// - Edited value reaches the parameter only on a set press.
// - After a completed setting, show end message, return to parameters.
// - After set outside diagnosis, show one status message for about one second.
// - Mode aborts: setting to parameter unsaved, parameter to monitor.
// - On fault show alarm_message prefix and two-digit code 1 to 23.
// - Display drives five seven-segment digits with all messages.
// - During diagnosis, set executes the final-step function.
// - Wide setting: shifting past the top digit lights all points.
// - Narrow setting: shifting past the top digit shows leading minus.
package kmc_pkg;

  //==========================================================
  // Timing
  localparam int CLK_HZ    = 25_000_000;
  localparam int MSG_MS    = 1000;
  localparam int DEB_MS    = 10;
  localparam int BLINK_MS  = 250;
  localparam int MSG_CYC   = CLK_HZ / 1000 * MSG_MS;
  localparam int DEB_CYC   = CLK_HZ / 1000 * DEB_MS;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int TMR_W     = 25;
  localparam int DEB_W     = 18;

  //==========================================================
  // Sizes and limits
  localparam int         NDIG     = 5;
  localparam int         NKEY     = 5;
  localparam logic [4:0] MON_INIT = 5'h00;
  localparam logic [4:0] MON_LAST = 5'h10;
  localparam logic [3:0] GRP_LAST = 4'h4;
  localparam logic [3:0] BCD_MAX  = 4'h9;
  localparam logic [4:0] DEC_TEN  = 5'h0a;
  localparam logic [4:0] DEC_20   = 5'h14;
  localparam logic [4:0] FLT_MIN  = 5'h01;
  localparam logic [4:0] FLT_MAX  = 5'h17;
  localparam logic [2:0] CUR_WIDE = 3'h4;
  localparam logic [2:0] CUR_NARR = 3'h3;

  //==========================================================
  // Glyphs: 0 to 15 are hex digits
  typedef logic [4:0] kmc_glyph_t;
  localparam kmc_glyph_t G_A    = 5'h0a;
  localparam kmc_glyph_t G_B    = 5'h0b;
  localparam kmc_glyph_t G_C    = 5'h0c;
  localparam kmc_glyph_t G_D    = 5'h0d;
  localparam kmc_glyph_t G_E    = 5'h0e;
  localparam kmc_glyph_t G_5    = 5'h05;
  localparam kmc_glyph_t G_1    = 5'h01;
  localparam kmc_glyph_t G_0    = 5'h00;
  localparam kmc_glyph_t G_2    = 5'h02;
  localparam kmc_glyph_t G_DASH = 5'h10;
  localparam kmc_glyph_t G_BLK  = 5'h11;
  localparam kmc_glyph_t G_L    = 5'h12;
  localparam kmc_glyph_t G_R    = 5'h13;
  localparam kmc_glyph_t G_N    = 5'h14;
  localparam kmc_glyph_t G_P    = 5'h15;
  localparam kmc_glyph_t G_O    = 5'h16;
  localparam kmc_glyph_t G_U    = 5'h17;

  //==========================================================
  // Types
  typedef struct packed {
    logic mode;
    logic shift;
    logic up;
    logic down;
    logic set;
  } kmc_keys_t;

  // Digit 4 is the leftmost; segments are gfedcba
  typedef struct packed {
    logic [NDIG-1:0][6:0] seg;
    logic [NDIG-1:0]      dp;
  } kmc_disp_t;

  typedef enum logic [2:0] {
    RES_OK, RES_RO, RES_PWD, RES_BAD, RES_RUN, RES_NOEE, RES_RESTART
  } kmc_res_t;

  typedef enum {
    S_SPLASH, S_MON_SYM, S_MON, S_PAR, S_SET, S_STAT, S_END
  } kmc_state_t;

  //==========================================================
  // Messages, leftmost glyph first
  localparam logic [24:0] MSG_END = {G_DASH, G_E, G_N, G_D, G_DASH};
  localparam logic [6:0][24:0] MSG_RES = {
    {G_P,    G_O, G_DASH, G_O,  G_N},
    {G_N,    G_O, G_DASH, G_E,  G_E},
    {G_5,    G_R, G_U,    G_N,  G_BLK},
    {G_B,    G_A, G_D,    G_DASH, G_DASH},
    {G_P,    G_A, G_5,    G_5,  G_DASH},
    {G_E,    G_R, G_R,    G_R,  G_R},
    {G_DASH, G_5, G_A,    G_U,  G_DASH}
  };

  function automatic logic [6:0] seg_of(input kmc_glyph_t g);
    logic [6:0] s;
    s = 7'h00;
    unique case (g)
      5'h00: s = 7'h3f;
      5'h01: s = 7'h06;
      5'h02: s = 7'h5b;
      5'h03: s = 7'h4f;
      5'h04: s = 7'h66;
      5'h05: s = 7'h6d;
      5'h06: s = 7'h7d;
      5'h07: s = 7'h07;
      5'h08: s = 7'h7f;
      5'h09: s = 7'h6f;
      5'h0a: s = 7'h77;
      5'h0b: s = 7'h7c;
      5'h0c: s = 7'h39;
      5'h0d: s = 7'h5e;
      5'h0e: s = 7'h79;
      5'h0f: s = 7'h71;
      5'h10: s = 7'h40;
      5'h12: s = 7'h38;
      5'h13: s = 7'h50;
      5'h14: s = 7'h54;
      5'h15: s = 7'h73;
      5'h16: s = 7'h5c;
      5'h17: s = 7'h1c;
      default: s = 7'h00;
    endcase
    return s;
  endfunction : seg_of

endpackage : kmc_pkg

// >>> rtl/kmc_debounce.sv
`timescale 1ns/1ps
module kmc_debounce #(
  parameter int DEB_CYC_P = kmc_pkg::DEB_CYC
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // Raw key levels and press pulses
  input  wire kmc_pkg::kmc_keys_t RAW,
  output kmc_pkg::kmc_keys_t      PRESS
);

  localparam logic [kmc_pkg::DEB_W-1:0] DEB_END =
    kmc_pkg::DEB_W'(DEB_CYC_P - 1);

  logic [kmc_pkg::NKEY-1:0] raw;
  logic [kmc_pkg::NKEY-1:0] press;

  assign raw   = RAW;
  assign PRESS = press;

  //==========================================================
  // Per-key filter: a level must hold the whole window to count
  genvar k;
  generate
    for (k = 0; k < kmc_pkg::NKEY; k++)
    begin : g_key
      logic [kmc_pkg::DEB_W-1:0] cnt_r, cnt_nxt;
      logic                      stab_r, stab_nxt;
      logic                      prs_r, prs_nxt;

      always_comb
      begin
        cnt_nxt  = '0;
        stab_nxt = stab_r;
        prs_nxt  = 1'b0;
        if (raw[k] != stab_r)
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == DEB_END)
          begin
            cnt_nxt  = '0;
            stab_nxt = raw[k];
            prs_nxt  = raw[k];
          end
        end
      end

      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          cnt_r  <= '0;
          stab_r <= 1'b0;
          prs_r  <= 1'b0;
        end
        else
        begin
          cnt_r  <= cnt_nxt;
          stab_r <= stab_nxt;
          prs_r  <= prs_nxt;
        end
      end

      assign press[k] = prs_r;

      press_single_a: assert property (
        @(posedge CLK) disable iff (RST) prs_r |=> !prs_r)
        else $error("key press lasted more than one cycle");
    end
  endgenerate

endmodule : kmc_debounce

// >>> verification/kmc_store_model.sv
`timescale 1ns/1ps
// ==========================================================
// Parameter store behind the menu: one cell, verdict from bench
module kmc_store_model (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // Write side
  input  wire logic              PAR_WR,
  input  wire logic [19:0]       PAR_WDATA,
  input  wire logic              PAR_WNEG,
  input  wire kmc_pkg::kmc_res_t RES_IN,
  // Answer side
  output kmc_pkg::kmc_res_t      SET_RESULT,
  output logic [19:0]            PAR_VALUE,
  output logic                   PAR_NEG
);
  // Verdict is combinational so it is valid in the write cycle
  assign SET_RESULT = RES_IN;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PAR_VALUE <= 20'h12345;
      PAR_NEG   <= 1'b0;
    end
    else if (PAR_WR && RES_IN == kmc_pkg::RES_OK)
    begin
      PAR_VALUE <= PAR_WDATA;
      PAR_NEG   <= PAR_WNEG;
    end
  end
endmodule : kmc_store_model

// >>> verification/kmc_top_bench.sv
`timescale 1ns/1ps
module kmc_top_bench;
  // ==========================================================
  // Sizes: short counts keep the run brief
  localparam int MSG  = 20;
  localparam int DEB  = 3;
  localparam int HOLD = DEB + 3;
  localparam int KM = 4, KS = 3, KU = 2, KD = 1, KT = 0;
  localparam logic [6:0] SEG7 [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
    7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  localparam logic [6:0] STAT [7] = '{7'h40, 7'h79, 7'h73, 7'h7c,
    7'h6d, 7'h54, 7'h73};

  logic               clk, rst, fault, diag, par_wide, par_neg, mon_neg;
  logic               par_wr, par_wneg, diag_exec;
  logic [4:0]         fault_code, mon_sel;
  logic [3:0]         par_group;
  logic [7:0]         par_index;
  logic [19:0]        mon_value, par_value, par_wdata, v, v0;
  kmc_pkg::kmc_keys_t keys;
  kmc_pkg::kmc_res_t  res, set_result;
  kmc_pkg::kmc_disp_t disp;
  logic [22:0]        expq[$];
  int                 num_errors = 0;
  int                 check_count = 0;

  kmc_top #(.MSG_CYC_P(MSG), .DEB_CYC_P(DEB), .BLINK_CYC_P(4)) dut (
    .CLK(clk), .RST(rst), .KEYS(keys), .FAULT(fault),
    .FAULT_CODE(fault_code), .DIAG(diag), .MON_SEL(mon_sel),
    .MON_VALUE(mon_value), .MON_NEG(mon_neg), .PAR_GROUP(par_group),
    .PAR_INDEX(par_index), .PAR_VALUE(par_value), .PAR_NEG(par_neg),
    .PAR_WIDE(par_wide), .PAR_WR(par_wr), .PAR_WDATA(par_wdata),
    .PAR_WNEG(par_wneg), .SET_RESULT(set_result),
    .DIAG_EXEC(diag_exec), .DISP(disp));

  kmc_store_model store (
    .CLK(clk), .RST(rst), .PAR_WR(par_wr), .PAR_WDATA(par_wdata),
    .PAR_WNEG(par_wneg), .RES_IN(res), .SET_RESULT(set_result),
    .PAR_VALUE(par_value), .PAR_NEG(par_neg));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // Checking helpers
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Each physical press outlasts the filter, then a full release
  task automatic press(input int k, input int n = 1);
    repeat (n)
    begin
      keys[k] <= 1'b1;
      repeat (HOLD) @(posedge clk);
      keys[k] <= 1'b0;
      repeat (HOLD) @(posedge clk);
    end
  endtask : press

  function automatic logic [19:0] bump(input logic [19:0] x, input int d,
                                       input bit up);
    logic [3:0] q;
    q = x[4*d +: 4];
    if (up)
      q = (q == 4'h9) ? 4'h0 : q + 4'h1;
    else
      q = (q == 4'h0) ? 4'h9 : q - 4'h1;
    x[4*d +: 4] = q;
    return x;
  endfunction : bump

  // Any write or diagnosis pulse must match the oldest note
  always @(posedge clk)
  begin
    if (!rst && (par_wr === 1'b1 || diag_exec === 1'b1))
    begin
      if (expq.size() == 0)
        check("unexpected write", 24'h1, 24'h0);
      else
        check("write", {diag_exec, par_wr, par_wneg, par_wdata},
              {1'b0, expq.pop_front()});
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(21));
    rst = 1'b1;
    keys = '0;
    fault = 1'b0;
    mon_neg = 1'b0;
    diag = 1'b0;
    par_wide = 1'b1;
    fault_code = 5'h00;
    res = kmc_pkg::RES_OK;
    for (int i = 0; i < 5; i++)
      mon_value[4*i +: 4] = 4'($urandom % 10);
    repeat (6) @(posedge clk);
    check("reset disp", 24'(|disp), 24'h0);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("splash", {disp.seg[4], disp.seg[2]}, {7'h39, 7'h40});
    repeat (MSG) @(posedge clk);
    check("monitor", disp.seg[0], SEG7[mon_value[3:0]]);
    press(KU);
    check("mon up", mon_sel, 5'h01);
    check("symbol", disp.seg[0], SEG7[1]);
    press(KD, 2);
    check("mon wrap", mon_sel, 5'h10);
    keys[KU] <= 1'b1;
    repeat (DEB - 1) @(posedge clk);
    keys[KU] <= 1'b0;
    repeat (HOLD) @(posedge clk);
    check("bounce", mon_sel, 5'h10);
    repeat (MSG) @(posedge clk);
    press(KM);
    check("par mode", disp.seg[4], 7'h73);
    press(KS);
    press(KU, 2);
    press(KD);
    check("group", {par_group, par_index}, {4'h1, 8'h01});
    for (int r = 0; r < 7; r++)
    begin
      res <= kmc_pkg::kmc_res_t'(r);
      press(KT);
      check("entry", par_wdata, par_value);
      v = par_value;
      v0 = v;
      press(KU);
      press(KS);
      press(KU);
      press(KS);
      press(KD);
      v = bump(bump(bump(v, 0, 1), 1, 1), 2, 0);
      check("edit", par_wdata, v);
      check("held", par_value, v0);
      expq.push_back({2'b01, par_neg, v});
      press(KT);
      check("status", disp.seg[4], STAT[r]);
      repeat (MSG) @(posedge clk);
      if (r == 0)
      begin
        check("end msg", disp.seg[3], 7'h79);
        repeat (MSG) @(posedge clk);
      end
      check("back", disp.seg[4], 7'h73);
    end
    v = par_value;
    press(KT);
    press(KU);
    press(KM);
    check("abort", {disp.seg[4], par_value}, {7'h73, v});
    press(KM);
    check("abort mon", disp.seg[0], SEG7[mon_value[3:0]]);
    mon_neg <= 1'b1;
    repeat (3) @(posedge clk);
    if (mon_value[19:16] != 4'h0)
      check("mon neg", disp.dp, 5'h1f);
    else
      check("mon neg", disp.seg[4], 7'h40);
    mon_neg <= 1'b0;
    press(KM);
    res <= kmc_pkg::RES_RO;
    press(KT);
    press(KS, 5);
    check("wide neg", disp.dp, 5'h1f);
    expq.push_back({2'b01, ~par_neg, par_value});
    press(KT);
    repeat (MSG) @(posedge clk);
    par_wide <= 1'b0;
    res <= kmc_pkg::RES_OK;
    press(KT);
    press(KS, 4);
    check("narrow neg", disp.seg[4], 7'h40);
    expq.push_back({2'b01, ~par_neg, par_value});
    press(KT);
    repeat (2 * MSG) @(posedge clk);
    diag <= 1'b1;
    press(KT);
    expq.push_back({2'b10, par_neg, par_value});
    press(KT);
    repeat (2 * MSG) @(posedge clk);
    diag <= 1'b0;
    for (int f = 0; f < 3; f++)
    begin
      fault <= 1'b1;
      fault_code <= (f == 0) ? 5'h00 : (f == 1) ? 5'h1e : 5'h11;
      repeat (3) @(posedge clk);
      check("alarm", {disp.seg[4], disp.seg[3], disp.seg[2]},
            {7'h77, 7'h38, 7'h79});
      check("code", {disp.seg[1], disp.seg[0]}, (f == 0) ?
            {SEG7[0], SEG7[1]} : (f == 1) ? {SEG7[2], SEG7[3]} :
            {SEG7[1], SEG7[7]});
    end
    check("pending", 24'(expq.size()), 24'h0);
    summarize();
  end
endmodule : kmc_top_bench
